// [hw/efh_pkg.sv]
// Purpose: constants shared by the ethernet fifo host status block
// Assumes: 32-bit ahb-lite register bus, word aligned registers
// Notes:   the six interrupt flag positions in status double as enable positions in control
package efh_pkg;
    // ==========================================================
    // register addresses
    localparam logic [31:0] ADDR_STATUS    = 32'hff800004;
    localparam logic [31:0] ADDR_DATA      = 32'hff800008;
    localparam logic [31:0] ADDR_DATA_LAST = 32'hff80000c;
    localparam logic [31:0] ADDR_CTRL      = 32'hff800040;
    // ==========================================================
    // status register fields
    localparam int BIT_RX_CODE_HI  = 29;
    localparam int BIT_RX_CODE_LO  = 28;
    localparam int BIT_RX_WORD_RDY = 27;
    localparam int BIT_RX_HALF     = 26;
    localparam int BIT_RX_PKT      = 25;
    localparam int BIT_RX_DISCARD  = 24;
    localparam int BIT_TX_SPACE    = 19;
    localparam int BIT_TX_HALF     = 18;
    localparam int BIT_TX_DONE     = 17;
    localparam int BIT_TX_EMPTY    = 16;
    localparam int BIT_PIN_RXD2    = 15;
    localparam int BIT_PIN_RXD1    = 13;
    localparam int BIT_PIN_RXD3    = 12;
    localparam int BIT_PIN_RXER    = 11;
    localparam int BIT_PIN_RXDV    = 10;
    // ==========================================================
    // control register fields
    localparam int BIT_ORDER       = 0;
    localparam int BIT_WMARK_LO    = 1;
    localparam int BIT_WMARK_HI    = 2;
    localparam logic [31:0] CTRL_WMASK = 32'h0e0e0007;
    // ==========================================================
    // reset values, thresholds and bus encodings
    localparam logic        TX_EMPTY_RESET = 1'b1;
    localparam int          RX_HALF_BYTES  = 1024;
    localparam int          TX_HALF_BYTES  = 256;
    localparam int          WORD_BYTES     = 4;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;
    localparam logic        HRESP_OKAY     = 1'h0;
    localparam int          WMARK_STEP     = 64;
endpackage

// [hw/efh_status_bank.sv]
// Purpose: fifo status flags, fifo data port and phy pin view over ahb-lite
// Assumes: fifo and mac engine run on clk; phy pins are asynchronous
// Notes:   one wait state on every nonseq word transfer; irq is a level
//
// What this block does
// - byte count code 00 word, 01 one, 10 half, 11 three bytes.
// - word-ready set when fifo data readable; interrupts with its enable.
// - word-ready stays low while packet-ready is set.
// - half-full set above 1024 bytes; interrupts with its enable.
// - packet-ready set on new packet; interrupts with its enable.
// - writing 1 clears packet-ready; then word-ready and half-full may rise.
// - writing discard clears packet-ready and flushes the current packet.
// - space-available set when transmit fifo accepts data; interrupts.
// - space-available stays low while frame-complete is set.
// - half-empty set when half the transmit fifo is free; interrupts.
// - frame-complete set when a packet finishes; interrupts.
// - writing 1 clears frame-complete; then space and half-empty may rise.
// - read-only fifo-empty flag high while transmit fifo empty; resets 1.
// - phy pin levels appear at bits 15, 13, 12, 11 and 10.
// - fifo data register written at primary and secondary address; read only at primary.
// - last word starts transmit with complete irq off, else watermark.
//
// Our own choice: the AHB-Lite slave port.
module efh_status_bank #(
    parameter int RX_LEVEL_W    = 12,
    parameter int TX_LEVEL_W    = 10,
    parameter int TX_FIFO_BYTES = 512
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  rxWordAvail,
    input  wire logic [2:0]            rxWordBytes,
    input  wire logic [31:0]           rxFifoData,
    input  wire logic [RX_LEVEL_W-1:0] rxFifoLevel,
    input  wire logic                  rxPacketArrive,
    output logic                       rxPop,
    output logic                       rxPacketDiscard,
    output logic                       rxByteOrder,
    input  wire logic [TX_LEVEL_W-1:0] txFifoLevel,
    input  wire logic                  txFrameDone,
    output logic                       txPush,
    output logic                       txPushLast,
    output logic      [31:0]           txData,
    output logic                       txStart,
    input  wire logic                  phyRxd1,
    input  wire logic                  phyRxd2,
    input  wire logic                  phyRxd3,
    input  wire logic                  phyRxer,
    input  wire logic                  phyRxdv,
    output logic                       irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // helpers
    function automatic logic [TX_LEVEL_W-1:0] wmBytes(input logic [1:0] c);
        wmBytes = TX_LEVEL_W'((int'(c) + 1) * efh_pkg::WMARK_STEP);
    endfunction
    function automatic logic isAddr(input logic [31:0] a,
                                    input logic [31:0] r);
        isAddr = (a == r);
    endfunction

    // ==========================================================
    // bus state
    logic        busy;
    logic [31:0] addrQ;
    logic        writeQ;
    logic [31:0] ctrl;
    logic        next_busy;
    logic [31:0] next_addrQ;
    logic        next_writeQ;
    logic [31:0] next_ctrl;
    logic [31:0] next_hrdata;
    logic        next_hreadyout;
    logic        next_rxPop;
    logic        next_txPush;
    logic        next_txPushLast;
    logic [31:0] next_txData;
    logic        wrStatus;

    // ==========================================================
    // flag state
    logic       rxWordReady;
    logic       rxHalfFull;
    logic       rxPacketReady;
    logic [1:0] rxCode;
    logic       txSpace;
    logic       txHalfEmpty;
    logic       txFrameComplete;
    logic       txEmpty;
    logic       txAtMark;
    logic       next_rxWordReady;
    logic       next_rxHalfFull;
    logic       next_rxPacketReady;
    logic [1:0] next_rxCode;
    logic       next_txSpace;
    logic       next_txHalfEmpty;
    logic       next_txFrameComplete;
    logic       next_txEmpty;
    logic       next_txAtMark;
    logic       next_txStart;
    logic       next_rxDiscard;
    logic       next_irq;
    logic [4:0] pinMeta;
    logic [4:0] pinSync;
    logic [31:0] statusWord;

    // ==========================================================
    // phy pins, two-flop synchroniser
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= {phyRxd2, phyRxd1, phyRxd3, phyRxer, phyRxdv};
            pinSync <= pinMeta;
        end
    end

    // ==========================================================
    // status word view
    always_comb begin
        statusWord = '0;
        statusWord[efh_pkg::BIT_RX_WORD_RDY] = rxWordReady;
        statusWord[efh_pkg::BIT_RX_HALF]     = rxHalfFull;
        statusWord[efh_pkg::BIT_RX_PKT]      = rxPacketReady;
        statusWord[efh_pkg::BIT_TX_SPACE]    = txSpace;
        statusWord[efh_pkg::BIT_TX_HALF]     = txHalfEmpty;
        statusWord[efh_pkg::BIT_TX_DONE]     = txFrameComplete;
        statusWord[efh_pkg::BIT_RX_CODE_HI:efh_pkg::BIT_RX_CODE_LO] = rxCode;
        statusWord[efh_pkg::BIT_TX_EMPTY] = txEmpty;
        statusWord[efh_pkg::BIT_PIN_RXD2] = pinSync[4];
        statusWord[efh_pkg::BIT_PIN_RXD1] = pinSync[3];
        statusWord[efh_pkg::BIT_PIN_RXD3] = pinSync[2];
        statusWord[efh_pkg::BIT_PIN_RXER] = pinSync[1];
        statusWord[efh_pkg::BIT_PIN_RXDV] = pinSync[0];
    end

    // ==========================================================
    // ahb-lite slave and fifo data port
    always_comb begin
        next_busy       = 1'b0;
        next_addrQ      = addrQ;
        next_writeQ     = writeQ;
        next_ctrl       = ctrl;
        next_hrdata     = hrdata;
        next_hreadyout  = 1'b1;
        next_rxPop      = 1'b0;
        next_txPush     = 1'b0;
        next_txPushLast = 1'b0;
        next_txData     = txData;
        wrStatus        = busy && writeQ
                          && isAddr(addrQ, efh_pkg::ADDR_STATUS);
        if (hsel && hready && htrans == efh_pkg::HTRANS_NONSEQ
                && hsize == efh_pkg::HSIZE_WORD) begin
            next_busy      = 1'b1;
            next_addrQ     = haddr;
            next_writeQ    = hwrite;
            next_hreadyout = 1'b0;
        end
        if (busy && writeQ) begin
            if (isAddr(addrQ, efh_pkg::ADDR_CTRL)) begin
                next_ctrl = hwdata & efh_pkg::CTRL_WMASK;
            end
            if (isAddr(addrQ, efh_pkg::ADDR_DATA)
                    || isAddr(addrQ, efh_pkg::ADDR_DATA_LAST)) begin
                next_txPush     = 1'b1;
                next_txData     = hwdata;
                next_txPushLast = isAddr(addrQ, efh_pkg::ADDR_DATA_LAST);
            end
        end else if (busy) begin
            next_hrdata = '0;
            if (isAddr(addrQ, efh_pkg::ADDR_STATUS)) begin
                next_hrdata = statusWord;
            end else if (isAddr(addrQ, efh_pkg::ADDR_CTRL)) begin
                next_hrdata = ctrl;
            end else if (isAddr(addrQ, efh_pkg::ADDR_DATA)) begin
                next_hrdata = rxFifoData;
                next_rxPop  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy       <= 1'b0;
            addrQ      <= '0;
            writeQ     <= 1'b0;
            ctrl       <= '0;
            hrdata     <= '0;
            hreadyout  <= 1'b1;
            hresp      <= efh_pkg::HRESP_OKAY;
            rxPop      <= 1'b0;
            txPush     <= 1'b0;
            txPushLast <= 1'b0;
            txData     <= '0;
        end else begin
            busy       <= next_busy;
            addrQ      <= next_addrQ;
            writeQ     <= next_writeQ;
            ctrl       <= next_ctrl;
            hrdata     <= next_hrdata;
            hreadyout  <= next_hreadyout;
            rxPop      <= next_rxPop;
            txPush     <= next_txPush;
            txPushLast <= next_txPushLast;
            txData     <= next_txData;
        end
    end

    // ==========================================================
    // status flags, transmit start and interrupt
    always_comb begin
        next_rxDiscard = wrStatus && hwdata[efh_pkg::BIT_RX_DISCARD];
        // a new packet wins over a clear in the same cycle
        next_rxPacketReady = rxPacketArrive || (rxPacketReady
            && !(wrStatus && hwdata[efh_pkg::BIT_RX_PKT])
            && !next_rxDiscard);
        next_rxWordReady = rxWordAvail && !next_rxPacketReady;
        next_rxHalfFull  = !next_rxPacketReady
            && int'(rxFifoLevel) > efh_pkg::RX_HALF_BYTES;
        next_rxCode = next_rxWordReady ? rxWordBytes[1:0] : 2'h0;
        next_txFrameComplete = txFrameDone || (txFrameComplete
            && !(wrStatus && hwdata[efh_pkg::BIT_TX_DONE]));
        next_txSpace = !next_txFrameComplete
            && int'(txFifoLevel) <= TX_FIFO_BYTES - efh_pkg::WORD_BYTES;
        next_txHalfEmpty = !next_txFrameComplete
            && int'(txFifoLevel) <= TX_FIFO_BYTES - efh_pkg::TX_HALF_BYTES;
        next_txEmpty  = (txFifoLevel == '0);
        next_txAtMark = (txFifoLevel == wmBytes(
            ctrl[efh_pkg::BIT_WMARK_HI:efh_pkg::BIT_WMARK_LO]));
        next_txStart  = ctrl[efh_pkg::BIT_TX_DONE]
            ? (next_txAtMark && !txAtMark)
            : (txPush && txPushLast);
        next_irq = |({next_rxWordReady, next_rxHalfFull,
                      next_rxPacketReady, next_txSpace,
                      next_txHalfEmpty, next_txFrameComplete}
                   & {ctrl[efh_pkg::BIT_RX_WORD_RDY],
                      ctrl[efh_pkg::BIT_RX_HALF],
                      ctrl[efh_pkg::BIT_RX_PKT],
                      ctrl[efh_pkg::BIT_TX_SPACE],
                      ctrl[efh_pkg::BIT_TX_HALF],
                      ctrl[efh_pkg::BIT_TX_DONE]});
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rxWordReady     <= 1'b0;
            rxHalfFull      <= 1'b0;
            rxPacketReady   <= 1'b0;
            rxCode          <= 2'h0;
            txSpace         <= 1'b0;
            txHalfEmpty     <= 1'b0;
            txFrameComplete <= 1'b0;
            txEmpty         <= efh_pkg::TX_EMPTY_RESET;
            txAtMark        <= 1'b0;
            txStart         <= 1'b0;
            rxPacketDiscard <= 1'b0;
            rxByteOrder     <= 1'b0;
            irq             <= 1'b0;
        end else begin
            rxWordReady     <= next_rxWordReady;
            rxHalfFull      <= next_rxHalfFull;
            rxPacketReady   <= next_rxPacketReady;
            rxCode          <= next_rxCode;
            txSpace         <= next_txSpace;
            txHalfEmpty     <= next_txHalfEmpty;
            txFrameComplete <= next_txFrameComplete;
            txEmpty         <= next_txEmpty;
            txAtMark        <= next_txAtMark;
            txStart         <= next_txStart;
            rxPacketDiscard <= next_rxDiscard;
            rxByteOrder     <= ctrl[efh_pkg::BIT_ORDER];
            irq             <= next_irq;
        end
    end

    // ==========================================================
    // checks

    AST_CODE_VALID: assert property (
        !rxWordReady |-> rxCode == 2'h0)
        else $error("byte code set without word ready");
    AST_WORD_BLOCKED: assert property (
        !(rxWordReady && rxPacketReady))
        else $error("word ready together with packet ready");
    AST_PKT_SET: assert property (
        rxPacketArrive |=> rxPacketReady)
        else $error("packet ready not set");
    AST_PKT_CLEAR: assert property (
        wrStatus && hwdata[efh_pkg::BIT_RX_PKT] && !rxPacketArrive
        |=> !rxPacketReady)
        else $error("packet ready not cleared");
    AST_DISCARD: assert property (
        wrStatus && hwdata[efh_pkg::BIT_RX_DISCARD] && !rxPacketArrive
        |=> rxPacketDiscard && !rxPacketReady ##1 !rxPacketDiscard)
        else $error("discard not a single pulse");
    AST_SPACE_BLOCKED: assert property (
        txFrameComplete |-> !txSpace && !txHalfEmpty)
        else $error("space shown while frame complete");
    AST_DONE_SET: assert property (
        txFrameDone |=> txFrameComplete)
        else $error("frame complete not set");
    AST_EMPTY: assert property (
        $past(txFifoLevel) == '0 |-> txEmpty)
        else $error("empty flag wrong");
    AST_LAST_START: assert property (
        txPush && txPushLast && !ctrl[efh_pkg::BIT_TX_DONE] |=> txStart)
        else $error("last word did not start transmit");
    AST_IRQ_PKT: assert property (
        rxPacketReady && ctrl[efh_pkg::BIT_RX_PKT]
        && $past(ctrl[efh_pkg::BIT_RX_PKT]) |-> irq)
        else $error("packet irq missing");
    AST_BUS_WAIT: assert property (
        busy |-> !hreadyout ##1 hreadyout)
        else $error("bus wait state wrong");

    CV_SKIP: cover property (rxPacketReady ##[1:50] rxPacketDiscard);
    CV_RX_READ: cover property (rxWordReady ##[1:20] rxPop);
    CV_TX_LAST: cover property (txPush && txPushLast ##1 txStart);
    CV_TX_CLEAR: cover property (txFrameComplete ##1 !txFrameComplete);
endmodule

// [testbench/efh_far_model.sv]
// Purpose: far side model of the rx and tx fifos and the mac engine
// Assumes: one clock; the bench loads packets and ends frames by tasks
// Notes:   rx data turns to its inverse once the fifo has run dry
module efh_far_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        rxPop,
    input  wire logic        rxPacketDiscard,
    input  wire logic        txPush,
    input  wire logic        txPushLast,
    input  wire logic [31:0] txData,
    input  wire logic        txStart,
    output logic             rxWordAvail,
    output logic [2:0]       rxWordBytes,
    output logic [31:0]      rxFifoData,
    output logic [11:0]      rxFifoLevel,
    output logic             rxPacketArrive,
    output logic [9:0]       txFifoLevel,
    output logic             txFrameDone
);
    timeunit 1ns;
    timeprecision 100ps;
    int          rxLevel = 0;
    int          txLevel = 0;
    int          pops = 0;
    int          starts = 0;
    int          discards = 0;
    logic [31:0] word;
    logic [31:0] lastTxData = 32'h0;
    logic        lastTxLast = 1'b0;
    // ==========================================================
    // fifo views
    assign word = 32'h5a000000 + 32'(pops);
    assign rxWordAvail = (rxLevel != 0);
    assign rxWordBytes = (rxLevel >= 4) ? 3'h4 : 3'(rxLevel);
    assign rxFifoData = rxWordAvail ? word : ~word;
    assign rxFifoLevel = 12'(rxLevel);
    assign txFifoLevel = 10'(txLevel);
    initial begin
        rxPacketArrive = 1'b0;
        txFrameDone = 1'b0;
    end
    // ==========================================================
    // fifo and mac behaviour
    always @(posedge clk) begin
        if (!resetn) begin
            rxLevel <= 0;
            txLevel <= 0;
            rxPacketArrive <= 1'b0;
            txFrameDone <= 1'b0;
        end else begin
            if (rxPop) begin
                pops <= pops + 1;
                rxLevel <= (rxLevel > 4) ? rxLevel - 4 : 0;
            end
            if (rxPacketDiscard) begin
                rxLevel <= 0;
                discards <= discards + 1;
            end
            if (txPush) begin
                txLevel <= txLevel + 4;
                lastTxData <= txData;
                lastTxLast <= txPushLast;
            end
            if (txStart) begin
                starts <= starts + 1;
            end
        end
    end
    task automatic rx_load(input int n);
        rxLevel <= n;
        rxPacketArrive <= 1'b1;
        @(posedge clk);
        rxPacketArrive <= 1'b0;
    endtask
    task automatic tx_finish();
        txLevel <= 0;
        txFrameDone <= 1'b1;
        @(posedge clk);
        txFrameDone <= 1'b0;
    endtask
endmodule

// [testbench/ethernet_fifo_host_status_tb.sv]
// Purpose: self-checking bench for the fifo host status bank
// Assumes: one ahb-lite slave, hreadyout fed back as hready
// Notes: fifos and mac are a behavioural model; dma never used
module ethernet_fifo_host_status_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] ST = efh_pkg::ADDR_STATUS;
    localparam logic [31:0] DA = efh_pkg::ADDR_DATA;
    localparam logic [31:0] DL = efh_pkg::ADDR_DATA_LAST;
    localparam logic [31:0] CT = efh_pkg::ADDR_CTRL;
    localparam logic [31:0] AL = 32'hffffffff;
    logic        clk, resetn, hsel, hwrite, hready, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rxFifoData, txData;
    logic [1:0]  htrans;
    logic [2:0]  hsize, rxWordBytes;
    logic [11:0] rxFifoLevel;
    logic [9:0]  txFifoLevel;
    logic        rxWordAvail, rxPacketArrive, rxPop, rxPacketDiscard;
    logic        rxByteOrder, txFrameDone, txPush, txStart, txPushLast;
    logic [4:0]  pins;
    int          failCount = 0;
    int          testsRun = 0;
    int          cycles = 0;
    // ==========================================================
    // design and far side
    efh_status_bank i_dut (.clk, .resetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hready), .hrdata,
        .hreadyout(hready), .hresp, .rxWordAvail, .rxWordBytes,
        .rxFifoData, .rxFifoLevel, .rxPacketArrive, .rxPop,
        .rxPacketDiscard, .rxByteOrder, .txFifoLevel, .txFrameDone,
        .txPush, .txPushLast, .txData, .txStart,
        .phyRxd2(pins[4]), .phyRxd1(pins[3]), .phyRxd3(pins[2]),
        .phyRxer(pins[1]), .phyRxdv(pins[0]), .irq);
    efh_far_model i_far (.clk, .resetn, .rxPop, .rxPacketDiscard,
        .txPush, .txPushLast, .txData, .txStart, .rxWordAvail,
        .rxWordBytes, .rxFifoData, .rxFifoLevel, .rxPacketArrive,
        .txFifoLevel, .txFrameDone);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failCount++;
            endSim();
        end
    end
    // ==========================================================
    // bus and compare helpers
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] w, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= efh_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic [31:0] r;
        repeat (3) @(posedge clk);
        bus(1'b0, a, 32'h0, r);
        cmp(r & m, e);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd(ST, AL, 32'h000d0000);
        cmp(32'(hresp), 32'h0);
        rd(32'hff800020, AL, 32'h0);
        rd(DL, AL, 32'h0);
        cmp(32'(i_far.pops), 32'h0);
        wr(CT, AL);
        rd(CT, AL, efh_pkg::CTRL_WMASK);
        cmp(32'(rxByteOrder), 32'h1);
        wr(CT, 32'h0);
    endtask
    task automatic t_pins();
        // pins read as with an endec phy
        pins <= 5'b10101;
        rd(ST, 32'h0000fc00, 32'h00009400);
        pins <= 5'b01010;
        rd(ST, 32'h0000fc00, 32'h00002800);
    endtask
    task automatic t_rx_word();
        wr(CT, 32'h08000000);
        i_far.rx_load(6);
        rd(ST, 32'h3f000000, 32'h02000000);
        cmp(32'(irq), 32'h0);
        wr(ST, 32'h0);
        rd(ST, 32'h3f000000, 32'h02000000);
        wr(ST, 32'h02000000);
        rd(ST, 32'h3f000000, 32'h08000000);
        cmp(32'(irq), 32'h1);
        rd(DA, AL, 32'h5a000000);
        rd(ST, 32'h3f000000, 32'h28000000);
        rd(DA, AL, 32'h5a000001);
        rd(ST, 32'h3f000000, 32'h0);
        cmp(32'(irq), 32'h0);
        i_far.rx_load(3);
        wr(ST, 32'h02000000);
        rd(ST, 32'h3f000000, 32'h38000000);
        wr(CT, 32'h0);
    endtask
    task automatic t_rx_half();
        i_far.rx_load(1024);
        wr(ST, 32'h02000000);
        rd(ST, 32'h0e000000, 32'h08000000);
        i_far.rx_load(1028);
        wr(CT, 32'h02000000);
        rd(ST, 32'h0e000000, 32'h02000000);
        cmp(32'(irq), 32'h1);
        wr(ST, 32'h02000000);
        rd(ST, 32'h0e000000, 32'h0c000000);
        i_far.rx_load(1028);
        wr(ST, 32'h01000000);
        rd(ST, 32'h0f000000, 32'h0);
        cmp(32'(i_far.discards), 32'h1);
        wr(CT, 32'h0);
    endtask
    task automatic t_tx_last();
        int s;
        s = i_far.starts;
        wr(DA, 32'h11111111);
        wr(DA, 32'h22222222);
        rd(ST, 32'h000f0000, 32'h000c0000);
        cmp(i_far.lastTxData, 32'h22222222);
        cmp(32'(i_far.lastTxLast), 32'h0);
        cmp(32'(i_far.starts - s), 32'h0);
        wr(DL, 32'h33333333);
        repeat (3) @(posedge clk);
        cmp(32'(i_far.starts - s), 32'h1);
        cmp(i_far.lastTxData, 32'h33333333);
        cmp(32'(i_far.lastTxLast), 32'h1);
        i_far.tx_finish();
        rd(ST, 32'h000f0000, 32'h00030000);
        wr(ST, 32'h00020000);
        rd(ST, 32'h000f0000, 32'h000d0000);
    endtask
    task automatic t_tx_mark();
        int s;
        wr(CT, 32'h00020000);
        s = i_far.starts;
        for (int i = 0; i < 15; i++) begin
            wr(DA, 32'(i));
        end
        repeat (3) @(posedge clk);
        cmp(32'(i_far.starts - s), 32'h0);
        wr(DA, 32'hf);
        repeat (3) @(posedge clk);
        cmp(32'(i_far.starts - s), 32'h1);
        i_far.tx_finish();
        rd(ST, 32'h000a0000, 32'h00020000);
        cmp(32'(irq), 32'h1);
        wr(ST, 32'h00020000);
        wr(CT, 32'h0);
    endtask
    task automatic endSim();
        if (failCount == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = efh_pkg::HSIZE_WORD;
        hwdata = 32'h0;
        pins = 5'h0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_pins();
        t_rx_word();
        t_rx_half();
        t_tx_last();
        t_tx_mark();
        endSim();
    end
endmodule
